// ==== asf_fp_detect.sv ====
`timescale 1ns/1ps
module asf_fp_detect (
   input wire logic fp_valid,
   input wire logic fp_is_divide,
   input wire logic fp_divisor_zero,
   input wire logic fp_dividend_finite_nonzero,
   input wire logic fp_inexact,
   input wire logic fp_too_small,
   input wire logic fp_too_large,
   input wire logic fp_reserved_input,
   input wire logic fp_reserved_result,
   input wire logic fp_indeterminate,
   output logic [asf_pkg::ASF_NUM_EXC-1:0] exc
);
   import asf_pkg::*;

   wire dz_hit = fp_is_divide & fp_divisor_zero & fp_dividend_finite_nonzero;
   wire res_hit = fp_reserved_input | fp_reserved_result;

   assign exc[ASF_EXC_DZ] = fp_valid & dz_hit;
   assign exc[ASF_EXC_X] = fp_valid & fp_inexact;
   assign exc[ASF_EXC_U] = fp_valid & fp_too_small;
   assign exc[ASF_EXC_V] = fp_valid & fp_too_large;
   assign exc[ASF_EXC_R] = fp_valid & res_hit;
   assign exc[ASF_EXC_N] = fp_valid & fp_indeterminate;
endmodule

// ==== asf_fp_flag_bit.sv ====
`timescale 1ns/1ps
module asf_fp_flag_bit (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic detect,
   input wire logic masked,
   input wire logic trap_taken,
   input wire logic sw_clear,
   output logic trap_flag,
   output logic sticky_flag
);
   import asf_pkg::*;

   // Set beats a software clear in the same cycle
   wire next_sticky = (detect & masked) | (sticky_flag & ~sw_clear);
   // A taken trap rewrites every trap bit, set or cleared
   wire next_trap = trap_taken ? detect : trap_flag;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sticky_flag <= ASF_FLAG_RST;
         trap_flag <= ASF_FLAG_RST;
      end else begin
         sticky_flag <= next_sticky;
         trap_flag <= next_trap;
      end
   end
endmodule

// ==== asf_pipe_model.sv ====
`timescale 1ns/1ps
module asf_pipe_model (
   input wire logic sys_clk,
   output logic exec_valid,
   output asf_pkg::asf_op_e op_class,
   output logic [31:0] operand_a,
   output logic [31:0] operand_b,
   output logic [5:0] ctl,
   output asf_pkg::asf_range_e range_check,
   output logic [31:0] instr_pc,
   output logic [31:0] logic_result,
   output logic product_overflow,
   output logic mts_write,
   output logic [3:0] mts_data,
   output logic fp_valid,
   output logic [8:0] fp_cond,
   output logic [5:0] sticky_clear
);
   import asf_pkg::*;

   task automatic idle();
      {exec_valid, ctl, product_overflow, mts_write, mts_data, fp_valid, fp_cond, sticky_clear} = '0;
      op_class = ASF_OP_NONE;
      range_check = ASF_RANGE_NONE;
   endtask
   initial begin
      {operand_a, operand_b, instr_pc, logic_result} = '0;
      idle();
   end
   // An edge passes between transfers, so no strobe is set twice in one step
   task automatic issue_start();
      @(posedge sys_clk);
      #1;
   endtask
   // Stale operands scrambled so a missed qualifier cannot pass by luck
   task automatic issue_end();
      @(posedge sys_clk);
      #1;
      idle();
      operand_a = ~operand_a;
      operand_b = ~operand_b;
      logic_result = ~logic_result;
   endtask
   task automatic op(input asf_op_e cls, input logic [31:0] a, b, input logic [5:0] c, input asf_range_e rng,
                     input logic pov);
      issue_start();
      exec_valid = 1'b1;
      op_class = cls;
      operand_a = a;
      operand_b = b;
      logic_result = a;
      ctl = c;
      range_check = rng;
      product_overflow = pov;
      instr_pc = instr_pc + 32'h4;
      issue_end();
   endtask
   task automatic mts(input logic [3:0] d);
      issue_start();
      mts_write = 1'b1;
      mts_data = d;
      issue_end();
   endtask
   task automatic fp(input logic [8:0] cond, input logic [5:0] clr);
      issue_start();
      fp_valid = |cond;
      fp_cond = cond;
      sticky_clear = clr;
      issue_end();
   endtask
endmodule

// ==== asf_pkg.sv ====
package asf_pkg;
   localparam int ASF_WORD_W = 32;
   localparam int ASF_NUM_EXC = 6;
   localparam int ASF_FLAG_W = 4;
   // Flag positions in the status write word
   localparam int ASF_FLAG_V = 3;
   localparam int ASF_FLAG_N = 2;
   localparam int ASF_FLAG_Z = 1;
   localparam int ASF_FLAG_C = 0;
   // Floating-point exception positions
   localparam int ASF_EXC_DZ = 0;
   localparam int ASF_EXC_X = 1;
   localparam int ASF_EXC_U = 2;
   localparam int ASF_EXC_V = 3;
   localparam int ASF_EXC_R = 4;
   localparam int ASF_EXC_N = 5;
   // Values after reset
   localparam logic ASF_FLAG_RST = 1'b0;
   localparam logic [ASF_WORD_W-1:0] ASF_WORD_RST = 32'h0000_0000;
   localparam logic [ASF_NUM_EXC-1:0] ASF_EXC_RST = 6'h00;

   typedef enum logic [1:0] {
      ASF_OP_NONE,
      ASF_OP_ARITH,
      ASF_OP_LOGIC,
      ASF_OP_PRODUCT
   } asf_op_e;

   typedef enum logic [1:0] {
      ASF_RANGE_NONE,
      ASF_RANGE_SIGNED,
      ASF_RANGE_UNSIGNED
   } asf_range_e;
endpackage

// ==== asf_status_unit.sv ====
`timescale 1ns/1ps
module asf_status_unit #(
   parameter int WIDTH = asf_pkg::ASF_WORD_W,
   parameter int NUM_EXC = asf_pkg::ASF_NUM_EXC
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic exec_valid,
   input asf_pkg::asf_op_e op_class,
   input wire logic [WIDTH-1:0] operand_a,
   input wire logic [WIDTH-1:0] operand_b,
   input wire logic subtract,
   input wire logic ones_complement,
   input wire logic use_carry_in,
   input wire logic divide_step,
   input wire logic step_shift,
   input wire logic shift_in,
   input asf_pkg::asf_range_e range_check,
   input wire logic [WIDTH-1:0] instr_pc,
   input wire logic [WIDTH-1:0] logic_result,
   input wire logic product_overflow,
   input wire logic product_overflow_trap_disable,
   input wire logic status_freeze_bit,
   input wire logic mts_write,
   input wire logic [asf_pkg::ASF_FLAG_W-1:0] mts_data,
   input wire logic fp_valid,
   input wire logic fp_is_divide,
   input wire logic fp_divisor_zero,
   input wire logic fp_dividend_finite_nonzero,
   input wire logic fp_inexact,
   input wire logic fp_too_small,
   input wire logic fp_too_large,
   input wire logic fp_reserved_input,
   input wire logic fp_reserved_result,
   input wire logic fp_indeterminate,
   input wire logic [NUM_EXC-1:0] fp_mask,
   input wire logic [NUM_EXC-1:0] sticky_clear,
   output logic overflow_flag,
   output logic negative_flag,
   output logic zero_flag,
   output logic carry_flag,
   output logic [WIDTH-1:0] result_word,
   output logic result_valid,
   output logic range_trap,
   output logic [WIDTH-1:0] trap_pc,
   output logic fp_trap,
   output logic [NUM_EXC-1:0] trap_flags,
   output logic [NUM_EXC-1:0] sticky_flags
);
   import asf_pkg::*;

   // Operation decode
   wire is_arith = exec_valid & (op_class == ASF_OP_ARITH);
   wire is_logic = exec_valid & (op_class == ASF_OP_LOGIC);
   wire is_product = exec_valid & (op_class == ASF_OP_PRODUCT);
   wire arith_go = is_arith & ~status_freeze_bit & ~mts_write;
   wire logic_go = is_logic & ~status_freeze_bit & ~mts_write;

   // Divide step adds or subtracts by sign of the partial remainder
   wire sub_eff = divide_step ? ~negative_flag : subtract;
   wire [WIDTH-1:0] b_eff = sub_eff ? ~operand_b : operand_b;
   // One's-complement subtract leaves carry in at zero
   wire cin = use_carry_in ? carry_flag : (sub_eff & ~ones_complement);
   wire [WIDTH:0] sum_full = {1'b0, operand_a} + {1'b0, b_eff} + {{WIDTH{1'b0}}, cin};
   wire [WIDTH-1:0] sum = sum_full[WIDTH-1:0];
   wire carry_out = sum_full[WIDTH];
   wire carry_into_top = operand_a[WIDTH-1] ^ b_eff[WIDTH-1] ^ sum[WIDTH-1];
   wire ovf = carry_into_top ^ carry_out;
   wire [WIDTH-1:0] written = step_shift ? {sum[WIDTH-2:0], shift_in} : sum;
   wire written_zero = (written == {WIDTH{1'b0}});
   wire logic_zero = (logic_result == {WIDTH{1'b0}});

   // Out-of-range detection; flags carry the cause only for arith ops not frozen or overridden by a status write
   wire unsigned_bad = sub_eff ? ~carry_out : carry_out;
   wire arith_trap = is_arith & ((range_check == ASF_RANGE_SIGNED) & ovf |
                                 (range_check == ASF_RANGE_UNSIGNED) & unsigned_bad);
   wire product_trap = is_product & product_overflow & ~product_overflow_trap_disable;
   wire next_range_trap = arith_trap | product_trap;

   // Flag next values; freeze and special writes are resolved here
   wire next_v = mts_write ? mts_data[ASF_FLAG_V] : (arith_go ? ovf : overflow_flag);
   wire next_n = mts_write ? mts_data[ASF_FLAG_N] :
                 arith_go ? sum[WIDTH-1] : (logic_go ? logic_result[WIDTH-1] : negative_flag);
   wire next_z = mts_write ? mts_data[ASF_FLAG_Z] :
                 arith_go ? written_zero : (logic_go ? logic_zero : zero_flag);
   wire next_c = mts_write ? mts_data[ASF_FLAG_C] : (arith_go ? carry_out : carry_flag);
   wire [WIDTH-1:0] next_result = is_arith ? written : logic_result;
   wire next_result_valid = is_arith | is_logic;

   // Flags are exported and read back by divide step and carry-in; no branch path reads them
   // Registered flags: the next instruction reads the new values
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         overflow_flag <= ASF_FLAG_RST;
         negative_flag <= ASF_FLAG_RST;
         zero_flag <= ASF_FLAG_RST;
         carry_flag <= ASF_FLAG_RST;
      end else begin
         overflow_flag <= next_v;
         negative_flag <= next_n;
         zero_flag <= next_z;
         carry_flag <= next_c;
      end
   end

   // Arith result is written even when the op traps; product ops write no result
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         result_word <= ASF_WORD_RST;
         result_valid <= ASF_FLAG_RST;
      end else begin
         result_valid <= next_result_valid;
         if (next_result_valid) begin
            result_word <= next_result;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         range_trap <= ASF_FLAG_RST;
         trap_pc <= ASF_WORD_RST;
      end else begin
         range_trap <= next_range_trap;
         if (next_range_trap) begin
            trap_pc <= instr_pc;
         end
      end
   end

   // Floating-point exceptions
   logic [NUM_EXC-1:0] exc;

   asf_fp_detect u_detect (
      .fp_valid(fp_valid),
      .fp_is_divide(fp_is_divide),
      .fp_divisor_zero(fp_divisor_zero),
      .fp_dividend_finite_nonzero(fp_dividend_finite_nonzero),
      .fp_inexact(fp_inexact),
      .fp_too_small(fp_too_small),
      .fp_too_large(fp_too_large),
      .fp_reserved_input(fp_reserved_input),
      .fp_reserved_result(fp_reserved_result),
      .fp_indeterminate(fp_indeterminate),
      .exc(exc)
   );

   // Any unmasked exception takes the trap
   wire next_fp_trap = |(exc & ~fp_mask);

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fp_trap <= ASF_FLAG_RST;
      end else begin
         fp_trap <= next_fp_trap;
      end
   end

   for (genvar i = 0; i < NUM_EXC; i++) begin : g_exc
      asf_fp_flag_bit u_bit (
         .sys_clk(sys_clk),
         .reset(reset),
         .detect(exc[i]),
         .masked(fp_mask[i]),
         .trap_taken(next_fp_trap),
         .sw_clear(sticky_clear[i]),
         .trap_flag(trap_flags[i]),
         .sticky_flag(sticky_flags[i])
      );
   end

   // Plain add kept apart from the datapath so the checks do not reuse it
   wire [WIDTH:0] plain_sum = {1'b0, operand_a} + {1'b0, operand_b};

   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   AST_DIVSTEP_SIGN: assert property (arith_go & divide_step & ~use_carry_in & negative_flag |=>
         carry_flag == $past(plain_sum[WIDTH]) && negative_flag == $past(plain_sum[WIDTH-1]))
      else $error("divide step ignored negative flag");
   AST_FREEZE_HOLD: assert property (status_freeze_bit & ~mts_write |=>
         $stable({overflow_flag, negative_flag, zero_flag, carry_flag}))
      else $error("flags changed while frozen");
   AST_QUIET_HOLD: assert property (~exec_valid & ~mts_write |=>
         $stable({overflow_flag, negative_flag, zero_flag, carry_flag}))
      else $error("flags changed with no instruction");
   AST_MTS_LOAD: assert property (mts_write |=>
         {overflow_flag, negative_flag, zero_flag, carry_flag} == $past(mts_data))
      else $error("status write not taken");
   AST_ZERO_WRITTEN: assert property (arith_go |=> zero_flag == (result_word == ASF_WORD_RST))
      else $error("zero flag disagrees with written word");
   AST_NEG_UNSHIFTED: assert property (arith_go & step_shift & ~sub_eff & ~use_carry_in |=>
         negative_flag == $past(plain_sum[WIDTH-1]))
      else $error("negative flag taken from shifted word");
   AST_OVF_SIGNS: assert property (arith_go & (operand_a[WIDTH-1] == b_eff[WIDTH-1]) |=>
         overflow_flag == ($past(sum[WIDTH-1]) != $past(operand_a[WIDTH-1])))
      else $error("overflow flag wrong");
   AST_LOGIC_VC: assert property (logic_go |=> $stable(overflow_flag) && $stable(carry_flag))
      else $error("logic op touched overflow or carry");
   AST_LOGIC_NZ: assert property (logic_go |=>
         negative_flag == result_word[WIDTH-1] && zero_flag == (result_word == ASF_WORD_RST))
      else $error("logic op negative or zero wrong");
   AST_PRODUCT_FLAGS: assert property (is_product & ~mts_write |=>
         $stable({overflow_flag, negative_flag, zero_flag, carry_flag}))
      else $error("product op changed flags");
   AST_TRAP_PC: assert property (range_trap |-> trap_pc == $past(instr_pc))
      else $error("trap address not saved");
   AST_UNSIGNED_SUB_CAUSE: assert property (arith_go & (range_check == ASF_RANGE_UNSIGNED) & sub_eff
         & ~carry_out |=> range_trap && !carry_flag)
      else $error("underflow trap cause wrong");
   AST_TRAP_BITS: assert property (fp_trap |-> trap_flags == $past(exc))
      else $error("trap bits do not match exceptions");
   AST_STICKY_KEEP: assert property (((($past(sticky_flags) & ~$past(sticky_clear)) & ~sticky_flags)
         == ASF_EXC_RST))
      else $error("sticky bit lost without software clear");
   AST_DZ_STICKY: assert property (fp_valid & fp_is_divide & fp_divisor_zero & fp_dividend_finite_nonzero
         & fp_mask[ASF_EXC_DZ] |=> sticky_flags[ASF_EXC_DZ])
      else $error("divide by zero not flagged");

   // Arithmetic and logic results and trap causes
   AST_CARRY_ADD: assert property (arith_go & ~sub_eff & ~use_carry_in |=>
         carry_flag == $past(plain_sum[WIDTH]))
      else $error("add carry flag wrong");
   AST_CARRY_SUB: assert property (arith_go & sub_eff & ~ones_complement & ~use_carry_in |=>
         carry_flag == $past(operand_a >= operand_b))
      else $error("subtract carry flag wrong");
   AST_ONES_SUB: assert property (arith_go & sub_eff & ones_complement & ~use_carry_in & ~step_shift |=>
         result_word == $past(operand_a - operand_b - {{(WIDTH-1){1'b0}}, 1'b1}))
      else $error("one's-complement subtract result wrong");
   AST_SIGNED_CAUSE: assert property (arith_go & (range_check == ASF_RANGE_SIGNED) |=>
         range_trap == overflow_flag)
      else $error("signed trap cause wrong");
   AST_UNSIGNED_ADD_CAUSE: assert property (arith_go & (range_check == ASF_RANGE_UNSIGNED) & ~sub_eff |=>
         range_trap == carry_flag)
      else $error("unsigned add trap cause wrong");
   AST_TRAP_RESULT: assert property (is_arith & ~sub_eff & ~use_carry_in & ~step_shift & (range_check != ASF_RANGE_NONE) |=>
         result_valid && result_word == $past(operand_a + operand_b))
      else $error("checked add result not written");
   AST_FREEZE_RESULT: assert property (is_arith & status_freeze_bit |=> result_valid)
      else $error("frozen arith op lost its result");
   AST_CIN_CHAIN: assert property (arith_go & use_carry_in & ~sub_eff & ~step_shift |=>
         result_word == $past(operand_a + operand_b + {{(WIDTH-1){1'b0}}, carry_flag}))
      else $error("carry chain add wrong");
   AST_LOGIC_RESULT: assert property (is_logic |=> result_valid && result_word == $past(logic_result))
      else $error("logic result not written");
   AST_QUIET_TRAP: assert property (~exec_valid |=> ~range_trap && ~result_valid)
      else $error("trap or result with no instruction");
   AST_PRODUCT_TRAP: assert property (is_product & product_overflow & ~product_overflow_trap_disable |=>
         range_trap)
      else $error("product overflow did not trap");
   AST_PRODUCT_NOTRAP: assert property (is_product & product_overflow_trap_disable |=> ~range_trap)
      else $error("disabled product trap taken");
   // Floating-point trap and sticky bits
   AST_FP_TRAP_TAKE: assert property (fp_valid & fp_inexact & ~fp_mask[ASF_EXC_X] |=>
         fp_trap && trap_flags[ASF_EXC_X])
      else $error("unmasked inexact did not trap");
   AST_TRAP_CLEAR: assert property (fp_trap & ~$past(fp_indeterminate) |-> ~trap_flags[ASF_EXC_N])
      else $error("stale invalid trap bit kept");
   AST_TRAP_HOLD: assert property (~next_fp_trap |=> $stable(trap_flags))
      else $error("trap bits changed with no trap");
   AST_DZ_ONLY: assert property (fp_valid & ~(fp_is_divide & fp_divisor_zero & fp_dividend_finite_nonzero) |=>
         ~fp_trap || ~trap_flags[ASF_EXC_DZ])
      else $error("divide by zero flagged without cause");
   AST_STICKY_SET: assert property (fp_valid & fp_too_small & fp_mask[ASF_EXC_U] |=>
         sticky_flags[ASF_EXC_U])
      else $error("masked underflow not sticky");
   AST_UNMASKED_NO_STICKY: assert property (fp_valid & fp_inexact & ~fp_mask[ASF_EXC_X] & ~sticky_flags[ASF_EXC_X] |=>
         ~sticky_flags[ASF_EXC_X])
      else $error("unmasked inexact set sticky bit");
   AST_FP_QUIET: assert property (~fp_valid |=> ~fp_trap)
      else $error("fp trap with no fp op");

   COV_RANGE_TRAP: cover property (arith_go ##1 range_trap);
   COV_PRODUCT_TRAP: cover property (is_product ##1 range_trap);
   COV_FREEZE_MTS: cover property (status_freeze_bit & mts_write);
   COV_FP_TRAP: cover property (fp_valid & next_fp_trap ##1 fp_trap);
   COV_STICKY_RACE: cover property (exc[ASF_EXC_X] & fp_mask[ASF_EXC_X] & sticky_clear[ASF_EXC_X]);
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
   import asf_pkg::*;
   localparam logic [5:0] SUB = 6'h20, ONES = 6'h10, CIN = 6'h08, DSTEP = 6'h04, SHFT = 6'h02, SIN = 6'h01;
   logic sys_clk, reset, status_freeze_bit, product_overflow_trap_disable;
   logic [5:0] fp_mask, sticky_clear, trap_flags, sticky_flags;
   logic exec_valid, product_overflow, mts_write, fp_valid, fp_trap, range_trap, result_valid;
   logic overflow_flag, negative_flag, zero_flag, carry_flag;
   asf_op_e op_class;
   asf_range_e range_check;
   logic [31:0] operand_a, operand_b, instr_pc, logic_result, result_word, trap_pc;
   logic [5:0] ctl;
   logic [3:0] mts_data, flags;
   logic [8:0] fp_cond;
   int n_errors = 0;
   int compares = 0;
   assign flags = {overflow_flag, negative_flag, zero_flag, carry_flag};
   asf_pipe_model i_pipe (.sys_clk, .exec_valid, .op_class, .operand_a, .operand_b, .ctl, .range_check,
      .instr_pc, .logic_result, .product_overflow, .mts_write, .mts_data, .fp_valid, .fp_cond, .sticky_clear);
   asf_status_unit i_dut (.sys_clk, .reset, .exec_valid, .op_class, .operand_a, .operand_b,
      .subtract(ctl[5]), .ones_complement(ctl[4]), .use_carry_in(ctl[3]), .divide_step(ctl[2]),
      .step_shift(ctl[1]), .shift_in(ctl[0]), .range_check, .instr_pc, .logic_result, .product_overflow,
      .product_overflow_trap_disable, .status_freeze_bit, .mts_write, .mts_data, .fp_valid,
      .fp_is_divide(fp_cond[0]), .fp_divisor_zero(fp_cond[1]), .fp_dividend_finite_nonzero(fp_cond[2]),
      .fp_inexact(fp_cond[3]), .fp_too_small(fp_cond[4]), .fp_too_large(fp_cond[5]),
      .fp_reserved_input(fp_cond[6]), .fp_reserved_result(fp_cond[7]), .fp_indeterminate(fp_cond[8]),
      .fp_mask, .sticky_clear, .overflow_flag, .negative_flag, .zero_flag, .carry_flag, .result_word,
      .result_valid, .range_trap, .trap_pc, .fp_trap, .trap_flags, .sticky_flags);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string what, input logic [31:0] exp, got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Flags checked 1 ns after the edge that samples the request
   task automatic ar(input logic [31:0] a, b, input logic [5:0] c, input asf_range_e rng, input logic [3:0] ef,
                     input logic [31:0] er, input logic et);
      i_pipe.op(ASF_OP_ARITH, a, b, c, rng, 1'b0);
      chk("flags", 32'(ef), 32'(flags));
      chk("result_word", er, result_word);
      chk("range_trap", 32'(et), 32'(range_trap));
      if (et === 1'b1) begin
         chk("trap_pc", instr_pc, trap_pc);
      end
   endtask
   task automatic lg(input asf_op_e cls, input logic [31:0] v, input logic pov, input logic [3:0] ef, input logic et);
      i_pipe.op(cls, v, 32'h0, 6'h00, ASF_RANGE_NONE, pov);
      chk("flags", 32'(ef), 32'(flags));
      chk("range_trap", 32'(et), 32'(range_trap));
   endtask
   task automatic ft(input logic [8:0] cond, input logic [5:0] clr, input logic etr, input logic [5:0] etf, est);
      i_pipe.fp(cond, clr);
      chk("fp_trap", 32'(etr), 32'(fp_trap));
      chk("trap_flags", 32'(etf), 32'(trap_flags));
      chk("sticky_flags", 32'(est), 32'(sticky_flags));
   endtask
   initial begin
      repeat (2000) @(posedge sys_clk);
      n_errors++;
      conclude();
   end
   initial begin
      logic [8:0] conds [7] = '{9'h007, 9'h008, 9'h010, 9'h020, 9'h040, 9'h080, 9'h100};
      logic [5:0] excs [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10, 6'h20};
      reset = 1'b1;
      status_freeze_bit = 1'b0;
      product_overflow_trap_disable = 1'b0;
      fp_mask = 6'h00;
      repeat (10) @(posedge sys_clk);
      #1;
      reset = 1'b0;
      chk("flags", 32'h0, 32'(flags));
      chk("sticky_flags", 32'h0, 32'(sticky_flags));
      $display("test reset done");
      ar(32'h1, 32'h1, SUB, ASF_RANGE_NONE, 4'b0011, 32'h0, 1'b0);
      ar(32'h7fffffff, 32'h1, 6'h00, ASF_RANGE_SIGNED, 4'b1100, 32'h80000000, 1'b1);
      ar(32'hffffffff, 32'h1, 6'h00, ASF_RANGE_UNSIGNED, 4'b0011, 32'h0, 1'b1);
      ar(32'h0, 32'h1, SUB, ASF_RANGE_UNSIGNED, 4'b0100, 32'hffffffff, 1'b1);
      ar(32'h5, 32'h3, SUB | ONES, ASF_RANGE_NONE, 4'b0001, 32'h1, 1'b0);
      ar(32'h0, 32'h0, CIN, ASF_RANGE_NONE, 4'b0000, 32'h1, 1'b0);
      ar(32'h80000000, 32'h0, DSTEP | SHFT, ASF_RANGE_NONE, 4'b0111, 32'h0, 1'b0);
      ar(32'h1, 32'h1, DSTEP | SHFT | SIN, ASF_RANGE_NONE, 4'b0000, 32'h5, 1'b0);
      $display("test arith done");
      i_pipe.mts(4'b1001);
      lg(ASF_OP_LOGIC, 32'h0, 1'b0, 4'b1011, 1'b0);
      lg(ASF_OP_LOGIC, 32'h80000000, 1'b0, 4'b1101, 1'b0);
      lg(ASF_OP_NONE, 32'h0, 1'b0, 4'b1101, 1'b0);
      $display("test logic done");
      status_freeze_bit = 1'b1;
      ar(32'h1, 32'h1, SUB, ASF_RANGE_NONE, 4'b1101, 32'h0, 1'b0);
      lg(ASF_OP_LOGIC, 32'h0, 1'b0, 4'b1101, 1'b0);
      i_pipe.mts(4'b0110);
      chk("flags", 32'h6, 32'(flags));
      status_freeze_bit = 1'b0;
      $display("test freeze done");
      lg(ASF_OP_PRODUCT, 32'h0, 1'b1, 4'b0110, 1'b1);
      chk("trap_pc", instr_pc, trap_pc);
      product_overflow_trap_disable = 1'b1;
      lg(ASF_OP_PRODUCT, 32'h0, 1'b1, 4'b0110, 1'b0);
      $display("test product done");
      for (int k = 0; k < 7; k++) begin
         ft(conds[k], 6'h00, 1'b1, excs[k], 6'h00);
      end
      ft(9'h003, 6'h00, 1'b0, 6'h20, 6'h00);
      fp_mask = 6'h3f;
      ft(9'h1ff, 6'h00, 1'b0, 6'h20, 6'h3f);
      fp_mask = 6'h3d;
      ft(9'h008, 6'h00, 1'b1, 6'h02, 6'h3f);
      ft(9'h000, 6'h05, 1'b0, 6'h02, 6'h3a);
      fp_mask = 6'h3f;
      ft(9'h008, 6'h02, 1'b0, 6'h02, 6'h3a);
      $display("test fp done");
      conclude();
   end
endmodule
